/* pkg/msc_pkg.sv */
/*
  Constants for the statistics counter bank: register offsets, counter
  indices, control fields, reset values, read states and timing.
  Assumes a 16-bit byte address window on an AXI4-Lite bus.
*/
package msc_pkg;
  // Counter offsets (byte addresses)
  localparam logic [15:0] OFS_CRC_ERR    = 16'h4000;
  localparam logic [15:0] OFS_ALIGN_ERR  = 16'h4004;
  localparam logic [15:0] OFS_BAD_SYM    = 16'h4008;
  localparam logic [15:0] OFS_PHY_RX_ERR = 16'h400C;
  localparam logic [15:0] OFS_MISSED     = 16'h4010;
  localparam logic [15:0] OFS_SINGLE_COL = 16'h4014;
  localparam logic [15:0] OFS_EXCESS_COL = 16'h4018;
  localparam logic [15:0] OFS_MULTI_COL  = 16'h401C;
  localparam logic [15:0] OFS_LATE_COL   = 16'h4020;
  localparam logic [15:0] OFS_TOTAL_COL  = 16'h4028;
  localparam logic [15:0] OFS_DEFER      = 16'h4030;
  localparam logic [15:0] OFS_NO_CRS     = 16'h4034;
  // Control register of the bank
  localparam logic [15:0] OFS_STAT_CTRL  = 16'h40F0;

  // Counter indices inside the bank
  localparam int IDX_CRC    = 0;
  localparam int IDX_ALIGN  = 1;
  localparam int IDX_SYM    = 2;
  localparam int IDX_PHYERR = 3;
  localparam int IDX_MISS   = 4;
  localparam int IDX_SINGLE = 5;
  localparam int IDX_EXCESS = 6;
  localparam int IDX_MULTI  = 7;
  localparam int IDX_LATE   = 8;
  localparam int IDX_TOTAL  = 9;
  localparam int IDX_DEFER  = 10;
  localparam int IDX_NOCRS  = 11;
  localparam int NUM_CNT    = 12;
  localparam int CNT_W      = 32;

  // Control register fields
  localparam int CTRL_RX_EN  = 0;
  localparam int CTRL_TX_EN  = 1;
  localparam int CTRL_HALF   = 2;
  localparam int CTRL_MII    = 3;
  localparam int CTRL_SPD100 = 4;
  localparam int CTRL_THR_LO = 8;
  localparam logic [7:0] THR_RESET = 8'h10;

  // Collision limits
  localparam logic [4:0] COLL_LIMIT = 5'h10;
  localparam logic [7:0] THR_LIMIT  = 8'h10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event deadline
  localparam int CLK_PERIOD_NS     = 50;
  localparam int EVENT_DEADLINE_NS = 1000;
  localparam int EVENT_DEADLINE_CYC = EVENT_DEADLINE_NS / CLK_PERIOD_NS;

  // Read channel states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } msc_rd_state_t;
endpackage : msc_pkg

/* rtl/msc_stats_top.sv */
/*
  Statistics counter bank of an Ethernet MAC: twelve clear-on-read,
  saturating counters fed by receive and transmit event pulses, plus a
  control register, all behind an AXI4-Lite slave.
  Assumes event inputs are one-cycle pulses synchronous to SYS_CLK_IN.
*/
module msc_stats_top #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              SYS_CLK_IN,
  input  wire logic              ARST_N_IN,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  // AXI4-Lite write response
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  // Receive path events
  input  wire logic              RX_FRAME_DONE_IN,
  input  wire logic              RX_ADDR_PASS_IN,
  input  wire logic              RX_LEN_GE64_IN,
  input  wire logic              RX_CRC_BAD_IN,
  input  wire logic              RX_ALIGN_BAD_IN,
  input  wire logic              RX_PHY_ERR_IN,
  input  wire logic              RX_BAD_SYMBOL_IN,
  input  wire logic              RX_MISS_IN,
  // Transmit path events
  input  wire logic              TX_DONE_IN,
  input  wire logic              TX_OK_IN,
  input  wire logic [4:0]        TX_COLL_NUM_IN,
  input  wire logic              TX_EXCESS_IN,
  input  wire logic              TX_LATE_COLL_IN,
  input  wire logic              TX_COLLISION_IN,
  input  wire logic              TX_DEFER_IN,
  input  wire logic              TX_DEFER_IPG_ONLY_IN,
  input  wire logic              TX_CRS_SEEN_IN,
  // Interrupt cause
  output logic                   RX_OVERRUN_CAUSE_OUT
);

  typedef logic [msc_pkg::NUM_CNT-1:0][msc_pkg::CNT_W-1:0] msc_bank_t;

  typedef struct packed {
    msc_bank_t             cnt;
    logic                  rx_en;
    logic                  transmit_enable_bit;
    logic                  half;
    logic                  mii;
    logic                  spd100;
    logic [7:0]            thr;
    msc_pkg::msc_rd_state_t rd_st;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic [ADDR_W-1:0]     awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  overrun;
  } msc_state_t;

  msc_state_t                  st_ff;
  msc_state_t                  nxt_st;
  logic [msc_pkg::NUM_CNT-1:0] inc;
  logic [msc_pkg::NUM_CNT-1:0] clr;
  logic                        ar_take;
  logic                        ar_hit;
  logic [3:0]                  ar_idx;
  logic                        rx_ok;
  logic                        tx_hd;
  logic                        tx_good;
  logic [31:0]                 ctrl_word;

  // Address to counter index, with hit flag in the top bit
  function automatic logic [4:0] map_addr(input logic [ADDR_W-1:0] a);
    logic [4:0] r;
    r = 5'h00;
    case (16'(a))
      msc_pkg::OFS_CRC_ERR:    r = 5'h10;
      msc_pkg::OFS_ALIGN_ERR:  r = 5'h11;
      msc_pkg::OFS_BAD_SYM:    r = 5'h12;
      msc_pkg::OFS_PHY_RX_ERR: r = 5'h13;
      msc_pkg::OFS_MISSED:     r = 5'h14;
      msc_pkg::OFS_SINGLE_COL: r = 5'h15;
      msc_pkg::OFS_EXCESS_COL: r = 5'h16;
      msc_pkg::OFS_MULTI_COL:  r = 5'h17;
      msc_pkg::OFS_LATE_COL:   r = 5'h18;
      msc_pkg::OFS_TOTAL_COL:  r = 5'h19;
      msc_pkg::OFS_DEFER:      r = 5'h1A;
      msc_pkg::OFS_NO_CRS:     r = 5'h1B;
      default:                 r = 5'h00;
    endcase
    return r;
  endfunction : map_addr

  // Read address decode and clear vector
  assign ar_take = S_AXI_ARVALID_IN && st_ff.arready;
  assign {ar_hit, ar_idx} = map_addr(S_AXI_ARADDR_IN);
  always_comb
  begin
    clr = '0;
    if (ar_take && ar_hit)
    begin
      clr[ar_idx] = 1'b1;
    end
  end

  // Control register image
  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[msc_pkg::CTRL_RX_EN]  = st_ff.rx_en;
    ctrl_word[msc_pkg::CTRL_TX_EN]  = st_ff.transmit_enable_bit;
    ctrl_word[msc_pkg::CTRL_HALF]   = st_ff.half;
    ctrl_word[msc_pkg::CTRL_MII]    = st_ff.mii;
    ctrl_word[msc_pkg::CTRL_SPD100] = st_ff.spd100;
    ctrl_word[msc_pkg::CTRL_THR_LO +: 8] = st_ff.thr;
  end

  // Event decode and gating
  always_comb
  begin
    inc = '0;
    // Frame accepted by filters and written to packet buffer
    rx_ok   = st_ff.rx_en && RX_FRAME_DONE_IN && RX_ADDR_PASS_IN
              && RX_LEN_GE64_IN;
    tx_hd   = st_ff.transmit_enable_bit && st_ff.half;
    tx_good = TX_DONE_IN && TX_OK_IN;
    inc[msc_pkg::IDX_CRC]    = rx_ok && RX_CRC_BAD_IN;
    inc[msc_pkg::IDX_ALIGN]  = rx_ok && RX_ALIGN_BAD_IN && st_ff.mii;
    inc[msc_pkg::IDX_SYM]    = RX_BAD_SYMBOL_IN;
    inc[msc_pkg::IDX_PHYERR] = rx_ok && RX_PHY_ERR_IN;
    inc[msc_pkg::IDX_MISS]   = st_ff.rx_en && RX_MISS_IN;
    inc[msc_pkg::IDX_SINGLE] = tx_hd && tx_good
                               && (TX_COLL_NUM_IN == 5'h01);
    inc[msc_pkg::IDX_EXCESS] = tx_hd && TX_EXCESS_IN
                               && (st_ff.thr >= msc_pkg::THR_LIMIT);
    inc[msc_pkg::IDX_MULTI]  = tx_hd && tx_good && (TX_COLL_NUM_IN > 5'h01)
                               && (TX_COLL_NUM_IN < msc_pkg::COLL_LIMIT);
    inc[msc_pkg::IDX_LATE]   = tx_hd && TX_LATE_COLL_IN;
    inc[msc_pkg::IDX_TOTAL]  = tx_hd && TX_COLLISION_IN;
    inc[msc_pkg::IDX_DEFER]  = st_ff.transmit_enable_bit && TX_DEFER_IN
                               && !TX_DEFER_IPG_ONLY_IN;
    inc[msc_pkg::IDX_NOCRS]  = st_ff.transmit_enable_bit && tx_good
                               && !TX_CRS_SEEN_IN
                               && (!st_ff.half || st_ff.spd100);
  end

  // Next state of the whole block
  always_comb
  begin
    nxt_st = st_ff;
    // Counters: clear on read, event wins into the fresh count
    for (int k = 0; k < msc_pkg::NUM_CNT; k++)
    begin
      if (clr[k])
      begin
        nxt_st.cnt[k] = inc[k] ? 32'h0000_0001 : 32'h0000_0000;
      end
      else if (inc[k] && (st_ff.cnt[k] != 32'hFFFF_FFFF))
      begin
        nxt_st.cnt[k] = st_ff.cnt[k] + 32'h0000_0001;
      end
    end
    // Overrun cause pulse
    nxt_st.overrun = inc[msc_pkg::IDX_MISS];
    // Read channel
    case (st_ff.rd_st)
      msc_pkg::RD_IDLE:
      begin
        if (ar_take)
        begin
          nxt_st.rd_st   = msc_pkg::RD_RESP;
          nxt_st.arready = 1'b0;
          nxt_st.rvalid  = 1'b1;
          nxt_st.rresp   = msc_pkg::RESP_OKAY;
          if (ar_hit)
          begin
            nxt_st.rdata = st_ff.cnt[ar_idx];
          end
          else if (16'(S_AXI_ARADDR_IN) == msc_pkg::OFS_STAT_CTRL)
          begin
            nxt_st.rdata = ctrl_word;
          end
          else
          begin
            nxt_st.rdata = 32'h0000_0000;
            nxt_st.rresp = msc_pkg::RESP_SLVERR;
          end
        end
      end
      msc_pkg::RD_RESP:
      begin
        if (S_AXI_RREADY_IN)
        begin
          nxt_st.rd_st   = msc_pkg::RD_IDLE;
          nxt_st.rvalid  = 1'b0;
          nxt_st.arready = 1'b1;
        end
      end
      default:
      begin
        nxt_st.rd_st   = msc_pkg::RD_IDLE;
        nxt_st.rvalid  = 1'b0;
        nxt_st.arready = 1'b1;
      end
    endcase
    // Write address and data taken in either order
    if (S_AXI_AWVALID_IN && st_ff.awready)
    begin
      nxt_st.awaddr  = S_AXI_AWADDR_IN;
      nxt_st.aw_got  = 1'b1;
      nxt_st.awready = 1'b0;
    end
    if (S_AXI_WVALID_IN && st_ff.wready)
    begin
      nxt_st.wdata  = S_AXI_WDATA_IN;
      nxt_st.wstrb  = S_AXI_WSTRB_IN;
      nxt_st.w_got  = 1'b1;
      nxt_st.wready = 1'b0;
    end
    // Write commit once both halves are held
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = msc_pkg::RESP_OKAY;
      if (16'(st_ff.awaddr) == msc_pkg::OFS_STAT_CTRL)
      begin
        if (st_ff.wstrb[0])
        begin
          nxt_st.rx_en  = st_ff.wdata[msc_pkg::CTRL_RX_EN];
          nxt_st.transmit_enable_bit = st_ff.wdata[msc_pkg::CTRL_TX_EN];
          nxt_st.half   = st_ff.wdata[msc_pkg::CTRL_HALF];
          nxt_st.mii    = st_ff.wdata[msc_pkg::CTRL_MII];
          nxt_st.spd100 = st_ff.wdata[msc_pkg::CTRL_SPD100];
        end
        if (st_ff.wstrb[1])
        begin
          nxt_st.thr = st_ff.wdata[msc_pkg::CTRL_THR_LO +: 8];
        end
      end
      else if (map_addr(st_ff.awaddr) == 5'h00)
      begin
        nxt_st.bresp = msc_pkg::RESP_SLVERR; // Unmapped writes refused
      end
    end
    // Write response retire
    if (st_ff.bvalid && S_AXI_BREADY_IN)
    begin
      nxt_st.bvalid  = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready  = 1'b1;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      st_ff         <= '0;
      st_ff.thr     <= msc_pkg::THR_RESET;
      st_ff.rd_st   <= msc_pkg::RD_IDLE;
      st_ff.arready <= 1'b1;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign S_AXI_AWREADY_OUT    = st_ff.awready;
  assign S_AXI_WREADY_OUT     = st_ff.wready;
  assign S_AXI_BRESP_OUT      = st_ff.bresp;
  assign S_AXI_BVALID_OUT     = st_ff.bvalid;
  assign S_AXI_ARREADY_OUT    = st_ff.arready;
  assign S_AXI_RDATA_OUT      = st_ff.rdata;
  assign S_AXI_RRESP_OUT      = st_ff.rresp;
  assign S_AXI_RVALID_OUT     = st_ff.rvalid;
  assign RX_OVERRUN_CAUSE_OUT = st_ff.overrun;

  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  localparam int DL_CYC = msc_pkg::EVENT_DEADLINE_CYC;
  logic [31:0] sel_cnt;
  assign sel_cnt = st_ff.cnt[ar_idx];

  sequence s_hit_read;
    ar_take && ar_hit;
  endsequence

  sequence s_resp_wait;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN;
  endsequence

  a_read_returns: assert property (s_hit_read |=> S_AXI_RDATA_OUT == $past(sel_cnt))
    else $error("read data differs from counter");
  a_read_clears: assert property (s_hit_read
    |=> st_ff.cnt[$past(ar_idx)] == {31'h0, $past(inc[ar_idx])})
    else $error("counter not cleared by read");
  a_resp_holds: assert property (s_resp_wait |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read response dropped early");
  a_overrun_pulse: assert property (st_ff.rx_en && RX_MISS_IN |=> RX_OVERRUN_CAUSE_OUT)
    else $error("missed frame without overrun cause");
  a_rx_gate_crc: assert property (!st_ff.rx_en && !clr[msc_pkg::IDX_CRC]
    |=> $stable(st_ff.cnt[msc_pkg::IDX_CRC]))
    else $error("crc count moved with receive off");
  a_excess_thr_low: assert property ((st_ff.thr < msc_pkg::THR_LIMIT)
    && !clr[msc_pkg::IDX_EXCESS] |=> $stable(st_ff.cnt[msc_pkg::IDX_EXCESS]))
    else $error("excessive count moved below threshold");
  a_defer_ipg_skip: assert property (TX_DEFER_IPG_ONLY_IN && !clr[msc_pkg::IDX_DEFER]
    |=> $stable(st_ff.cnt[msc_pkg::IDX_DEFER]))
    else $error("defer count moved for gap wait");
  a_nocrs_10_half: assert property (st_ff.half && !st_ff.spd100 && !clr[msc_pkg::IDX_NOCRS]
    |=> $stable(st_ff.cnt[msc_pkg::IDX_NOCRS]))
    else $error("no-carrier count moved at 10 Mb/s half duplex");
  a_deadline_fit: assert property (RX_BAD_SYMBOL_IN && (st_ff.cnt[msc_pkg::IDX_SYM] == 32'h0)
    |-> ##[1:DL_CYC] (st_ff.cnt[msc_pkg::IDX_SYM] != 32'h0))
    else $error("symbol event missed its deadline");

  for (genvar g = 0; g < msc_pkg::NUM_CNT; g++)
  begin : g_chk
    a_cnt_step: assert property (inc[g] && !clr[g] && (st_ff.cnt[g] != 32'hFFFF_FFFF)
      |=> st_ff.cnt[g] == $past(st_ff.cnt[g]) + 32'h1)
      else $error("counter missed an event");
    a_cnt_stick: assert property ((st_ff.cnt[g] == 32'hFFFF_FFFF) && !clr[g]
      |=> st_ff.cnt[g] == 32'hFFFF_FFFF)
      else $error("saturated counter wrapped");
  end

endmodule : msc_stats_top

/* tb/test_msc_stats_top.sv */
/*
  Self-checking bench for the statistics counter bank: AXI4-Lite read and
  write tasks, event pulse driver and per-phase expected counter tables.
  Assumes the package constants and the register timing of the bank.
*/
module test_msc_stats_top;
  timeunit 1ns;
  timeprecision 1ns;

  // Event vector bit positions
  localparam logic [15:0] EV_DONE  = 16'h0001;
  localparam logic [15:0] EV_PASS  = 16'h0002;
  localparam logic [15:0] EV_GE64  = 16'h0004;
  localparam logic [15:0] EV_CRC   = 16'h0008;
  localparam logic [15:0] EV_ALIGN = 16'h0010;
  localparam logic [15:0] EV_PHY   = 16'h0020;
  localparam logic [15:0] EV_SYM   = 16'h0040;
  localparam logic [15:0] EV_MISS  = 16'h0080;
  localparam logic [15:0] TX_DONE  = 16'h0100;
  localparam logic [15:0] TX_OK    = 16'h0200;
  localparam logic [15:0] TX_EXC   = 16'h0400;
  localparam logic [15:0] TX_LATE  = 16'h0800;
  localparam logic [15:0] TX_COL   = 16'h1000;
  localparam logic [15:0] TX_DEF   = 16'h2000;
  localparam logic [15:0] TX_IPG   = 16'h4000;
  localparam logic [15:0] TX_CRS   = 16'h8000;
  localparam logic [15:0] RX_ALL   = 16'h003F;
  localparam int          LIMIT    = 20000;
  localparam logic [15:0] OFS_TAB [12] = '{msc_pkg::OFS_CRC_ERR, msc_pkg::OFS_ALIGN_ERR,
    msc_pkg::OFS_BAD_SYM, msc_pkg::OFS_PHY_RX_ERR, msc_pkg::OFS_MISSED, msc_pkg::OFS_SINGLE_COL,
    msc_pkg::OFS_EXCESS_COL, msc_pkg::OFS_MULTI_COL, msc_pkg::OFS_LATE_COL,
    msc_pkg::OFS_TOTAL_COL, msc_pkg::OFS_DEFER, msc_pkg::OFS_NO_CRS};

  logic        clk;
  logic        arst_n;
  logic [15:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic [3:0]  wstrb;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [15:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] ev;
  logic [4:0]  coll;
  logic        overrun;
  logic [31:0] exp_cnt [12];
  int          num_errors;
  int          compares;
  int          cyc;

  msc_stats_top dut_u (
    .SYS_CLK_IN           (clk),
    .ARST_N_IN            (arst_n),
    .S_AXI_AWADDR_IN      (awaddr),
    .S_AXI_AWVALID_IN     (awvalid),
    .S_AXI_AWREADY_OUT    (awready),
    .S_AXI_WDATA_IN       (wdata),
    .S_AXI_WSTRB_IN       (wstrb),
    .S_AXI_WVALID_IN      (wvalid),
    .S_AXI_WREADY_OUT     (wready),
    .S_AXI_BRESP_OUT      (bresp),
    .S_AXI_BVALID_OUT     (bvalid),
    .S_AXI_BREADY_IN      (bready),
    .S_AXI_ARADDR_IN      (araddr),
    .S_AXI_ARVALID_IN     (arvalid),
    .S_AXI_ARREADY_OUT    (arready),
    .S_AXI_RDATA_OUT      (rdata),
    .S_AXI_RRESP_OUT      (rresp),
    .S_AXI_RVALID_OUT     (rvalid),
    .S_AXI_RREADY_IN      (rready),
    .RX_FRAME_DONE_IN     (ev[0]),
    .RX_ADDR_PASS_IN      (ev[1]),
    .RX_LEN_GE64_IN       (ev[2]),
    .RX_CRC_BAD_IN        (ev[3]),
    .RX_ALIGN_BAD_IN      (ev[4]),
    .RX_PHY_ERR_IN        (ev[5]),
    .RX_BAD_SYMBOL_IN     (ev[6]),
    .RX_MISS_IN           (ev[7]),
    .TX_DONE_IN           (ev[8]),
    .TX_OK_IN             (ev[9]),
    .TX_COLL_NUM_IN       (coll),
    .TX_EXCESS_IN         (ev[10]),
    .TX_LATE_COLL_IN      (ev[11]),
    .TX_COLLISION_IN      (ev[12]),
    .TX_DEFER_IN          (ev[13]),
    .TX_DEFER_IPG_ONLY_IN (ev[14]),
    .TX_CRS_SEEN_IN       (ev[15]),
    .RX_OVERRUN_CAUSE_OUT (overrun)
  );

  // Verdict and end of run
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // AXI4-Lite write, response checked
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr

  // AXI4-Lite read, optional event launched at the address edge
  task automatic rd(input logic [15:0] a, input logic [15:0] evm, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ev      <= evm;
    do
    begin
      @(posedge clk);
      ev <= '0;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // One-cycle event pulse
  task automatic evp(input logic [15:0] m, input logic [4:0] c);
    @(posedge clk);
    ev   <= m;
    coll <= c;
    @(posedge clk);
    ev <= '0;
  endtask : evp

  // Read every counter, then read again expecting cleared values
  task automatic rd_all;
    for (int i = 0; i < 12; i++) rd(OFS_TAB[i], 16'h0, exp_cnt[i], msc_pkg::RESP_OKAY);
    for (int i = 0; i < 12; i++) rd(OFS_TAB[i], 16'h0, 32'h0, msc_pkg::RESP_OKAY);
  endtask : rd_all

  // Clock source
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Watchdog
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      num_errors++;
      end_sim();
    end
  end

  // Main sequence
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    ev = '0;
    coll = '0;
    wstrb = 4'hF;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    arst_n = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    exp_cnt = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    rd_all();
    rd(msc_pkg::OFS_STAT_CTRL, 16'h0, 32'h0000_1000, msc_pkg::RESP_OKAY);
    rd(16'h4024, 16'h0, 32'h0, msc_pkg::RESP_SLVERR);
    rd(16'h4002, 16'h0, 32'h0, msc_pkg::RESP_SLVERR);
    axi_wr(msc_pkg::OFS_CRC_ERR, 32'h0000_0005, msc_pkg::RESP_OKAY);
    axi_wr(16'h4024, 32'h0000_0000, msc_pkg::RESP_SLVERR);
    // All enables off: only bad symbols count
    evp(RX_ALL, 5'h00);
    evp(EV_MISS, 5'h00);
    @(posedge clk);
    chk({31'h0, overrun}, 32'h0);
    evp(EV_SYM, 5'h00);
    evp(TX_DONE | TX_OK, 5'h01);
    evp(TX_COL | TX_DEF, 5'h00);
    exp_cnt = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    rd_all();
    // Receive, transmit, half duplex, MII mode, threshold 16
    axi_wr(msc_pkg::OFS_STAT_CTRL, 32'h0000_100F, msc_pkg::RESP_OKAY);
    rd(msc_pkg::OFS_STAT_CTRL, 16'h0, 32'h0000_100F, msc_pkg::RESP_OKAY);
    evp(RX_ALL, 5'h00);
    evp(EV_DONE | EV_PASS | EV_CRC | EV_PHY, 5'h00);
    evp(EV_DONE | EV_GE64 | EV_CRC | EV_ALIGN, 5'h00);
    evp(EV_MISS, 5'h00);
    @(posedge clk);
    chk({31'h0, overrun}, 32'h1);
    @(posedge clk);
    chk({31'h0, overrun}, 32'h0);
    evp(TX_DONE | TX_OK | TX_CRS, 5'h01);
    evp(TX_DONE | TX_OK | TX_CRS, 5'h02);
    evp(TX_DONE | TX_OK | TX_CRS, 5'h0F);
    evp(TX_DONE | TX_CRS, 5'h03);
    evp(TX_EXC, 5'h10);
    evp(TX_LATE, 5'h00);
    repeat (3) evp(TX_COL, 5'h00);
    evp(TX_DEF, 5'h00);
    evp(TX_DEF | TX_IPG, 5'h00);
    evp(TX_DONE | TX_OK, 5'h00);
    repeat (2) @(posedge clk);
    exp_cnt = '{1, 1, 0, 1, 1, 1, 1, 2, 1, 3, 1, 0};
    rd_all();
    // Threshold 15, MII off, 100 Mb/s half duplex
    axi_wr(msc_pkg::OFS_STAT_CTRL, 32'h0000_0F17, msc_pkg::RESP_OKAY);
    evp(TX_EXC, 5'h10);
    evp(RX_ALL, 5'h00);
    evp(TX_DONE | TX_OK, 5'h00);
    evp(TX_DONE | TX_OK | TX_CRS, 5'h00);
    exp_cnt = '{1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 1};
    rd_all();
    // Transmit only, full duplex
    axi_wr(msc_pkg::OFS_STAT_CTRL, 32'h0000_1002, msc_pkg::RESP_OKAY);
    evp(TX_DONE | TX_OK | TX_CRS, 5'h01);
    evp(TX_COL | TX_LATE | TX_EXC, 5'h00);
    evp(TX_DEF, 5'h00);
    evp(TX_DONE | TX_OK, 5'h00);
    exp_cnt = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
    rd_all();
    // Byte strobes: only the threshold byte lands
    wstrb <= 4'h2;
    axi_wr(msc_pkg::OFS_STAT_CTRL, 32'h0000_0C1F, msc_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(msc_pkg::OFS_STAT_CTRL, 16'h0, 32'h0000_0C02, msc_pkg::RESP_OKAY);
    // Event landing on the edge of a clearing read
    repeat (2) evp(EV_SYM, 5'h00);
    rd(msc_pkg::OFS_BAD_SYM, EV_SYM, 32'h2, msc_pkg::RESP_OKAY);
    rd(msc_pkg::OFS_BAD_SYM, 16'h0, 32'h1, msc_pkg::RESP_OKAY);
    end_sim();
  end
endmodule : test_msc_stats_top
